// File: bench/tb.sv
// Self-checking bench for the strap loader, start-up sequencer and read port.
// Assumes vrsc_host as the link partner and the constants of vrsc_pkg.
module tb import vrsc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic enable_pin = 1'b0;
   logic system_power_input = 1'b0;
   logic [3:0] phase_sense_input = 4'b1000;
   logic [7:0] strap_code = 8'h00;
   logic [1:0] first_pulse = 2'h0, power_state = 2'h0, light_load = 2'h0;
   logic [7:0] cur_main = 8'h00, cur_a = 8'h00, pow_main = 8'h00, pow_a = 8'h00;
   logic [7:0] system_power_input_code = 8'h00, aux_code = 8'h00;
   logic [7:0] code_tbl [0:7];
   logic [7:0] row_tbl [0:4] = '{8'h08, 8'h4C, 8'hBF, 8'hDD, 8'h8C};
   wire vid_clk, vid_data_in, vid_data_out, vid_data_oe_n, strap_src_en, driver_enable_out, regulator_ready;
   wire [2:0] strap_sel, phase_count;
   wire [4:0] pwm_mid;
   wire [8:0] dac_main, dac_a;
   wire [3:0] freq_sel_main, freq_sel_a;
   wire [1:0] rail_ripple, rail_dcm, freq_floor;
   logic [8:0] exp_q [$];
   int err_count = 0;
   int checks_done = 0;
   // Random source; seed 43598
   logic [15:0] lfsr_q = 16'hAA4E;

   vrsc_top vrsc_top_inst (.mclk(mclk), .reset_n(reset_n), .enable_pin(enable_pin),
      .phase_sense_input(phase_sense_input), .system_power_input(system_power_input),
      .strap_code(strap_code), .first_pulse(first_pulse), .power_state(power_state),
      .light_load(light_load), .cur_main(cur_main), .cur_a(cur_a), .pow_main(pow_main),
      .pow_a(pow_a), .system_power_input_code(system_power_input_code), .aux_code(aux_code), .vid_clk(vid_clk),
      .vid_data_in(vid_data_in), .vid_data_out(vid_data_out), .vid_data_oe_n(vid_data_oe_n),
      .strap_sel(strap_sel), .strap_src_en(strap_src_en), .driver_enable_out(driver_enable_out),
      .regulator_ready(regulator_ready), .pwm_mid(pwm_mid), .dac_main(dac_main), .dac_a(dac_a),
      .phase_count(phase_count), .freq_sel_main(freq_sel_main), .freq_sel_a(freq_sel_a),
      .rail_ripple(rail_ripple), .rail_dcm(rail_dcm), .freq_floor(freq_floor));
   vrsc_host vrsc_host_inst (.vid_clk(vid_clk), .vid_data_in(vid_data_in), .vid_data_out(vid_data_out),
      .vid_data_oe_n(vid_data_oe_n));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   always #5 mclk = ~mclk;

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   // A code that lands inside resistor bin k
   function automatic logic [7:0] bin_code(input int k);
      return (k == 0) ? 8'h0A : BIN_MID[k - 1] + 8'h01;
   endfunction : bin_code

   task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic rd(input logic [3:0] a, input logic [7:0] i, input logic [8:0] e);
      exp_q.push_back(e);
      vrsc_host_inst.read(a, i);
   endtask : rd

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   // Simulated ADC follows the strap pin being measured
   always @(posedge mclk) strap_code <= code_tbl[strap_sel];

   // Each finished frame is compared with the oldest expectation
   always @(vrsc_host_inst.frame_done) begin
      check("read", exp_q.pop_front(), vrsc_host_inst.got);
   end

   // Watchdog
   initial begin
      repeat (40000) @(posedge mclk);
      err_count++;
      stop_test();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int n;
      code_tbl = '{bin_code(7), bin_code(3), bin_code(5), bin_code(12), bin_code(3), 8'h00, 8'h00, 8'h00};
      for (int k = 5; k < 8; k++) begin
         lfsr_q = lfsr_next(lfsr_q);
         code_tbl[k] = lfsr_q[7:0];
      end
      repeat (2) @(negedge mclk);
      check("pwm_rst", 9'h01F, 9'(pwm_mid));
      for (int pass = 0; pass < 2; pass++) begin
         @(posedge mclk);
         reset_n <= 1'b1;
         repeat (3) @(negedge mclk);
         check("src_en", 9'h001, 9'(strap_src_en));
         for (int i = 0; i < 8100 && strap_src_en !== 1'b0; i++) @(negedge mclk);
         // Decoded settings reach the pins one cycle after the wait state is entered
         repeat (2) @(negedge mclk);
         check("pwm_collect", 9'h01F, 9'(pwm_mid));
         check("phases", 9'h003, 9'(phase_count));
         check("freq", 9'h05C, 9'({freq_sel_main, freq_sel_a}));
         if (pass == 1) begin
            rd(ADDR_SYSTEM_POWER_INPUT, REG_OUTPUT_POWER_READING, 9'h000);
            rd(ADDR_MAIN, REG_PEAK, {1'b1, code_tbl[5]});
            break;
         end
         @(posedge mclk);
         lfsr_q = lfsr_next(lfsr_q);
         {cur_main, cur_a} <= lfsr_q;
         lfsr_q = lfsr_next(lfsr_q);
         {pow_main, pow_a} <= lfsr_q;
         lfsr_q = lfsr_next(lfsr_q);
         {system_power_input_code, aux_code} <= lfsr_q;
         enable_pin <= 1'b1;
         for (int i = 0; i < 10 && driver_enable_out !== 1'b1; i++) @(negedge mclk);
         check("drv_en", 9'h001, 9'(driver_enable_out));
         for (int i = 0; i < 200 && dac_main !== 9'h001; i++) @(negedge mclk);
         check("ramp_mid", 9'h01F, 9'({regulator_ready, pwm_mid[3:0]} | 5'h10));
         n = 0;
         while (dac_main === 9'h001 && n < 200) begin
            @(negedge mclk);
            n++;
         end
         check("step_cyc", 9'(STEP_FINE_MV * 1000 / (SR_TBL[7 % 3] * CLK_NS)), 9'(n));
         for (int i = 0; i < 4000 && (dac_main !== 9'd210 || dac_a !== 9'd210); i++) @(negedge mclk);
         check("boot_main", 9'(V105_MV / STEP_FINE_MV), dac_main);
         check("boot_a", 9'(V105_MV / STEP_FINE_MV), dac_a);
         repeat (3) @(negedge mclk);
         check("ready", 9'h001, 9'(regulator_ready));
         @(posedge mclk);
         first_pulse <= 2'b01;
         @(posedge mclk);
         first_pulse <= 2'b00;
         repeat (3) @(negedge mclk);
         check("pwm_main", 9'h002, 9'({pwm_mid[4], pwm_mid[0]}));
         @(posedge mclk);
         first_pulse <= 2'b10;
         @(posedge mclk);
         first_pulse <= 2'b00;
         repeat (3) @(negedge mclk);
         check("pwm_a", 9'h000, 9'({pwm_mid[4], pwm_mid[0]}));
         // Power state table: state, light load, ripple, discontinuous
         for (int r = 0; r < 5; r++) begin
            @(posedge mclk);
            {power_state, light_load} <= row_tbl[r][7:4];
            repeat (4) @(negedge mclk);
            check("conduction", 9'(row_tbl[r][3:0]), 9'({rail_ripple, rail_dcm}));
            check("floor", 9'(row_tbl[r][1:0]), 9'(freq_floor));
         end
         rd(ADDR_MAIN, REG_PEAK, {1'b1, code_tbl[5]});
         rd(ADDR_A_HI, REG_PEAK, {1'b1, code_tbl[6]});
         rd(ADDR_A_LO, REG_PEAK, 9'h000);
         rd(ADDR_MAIN, REG_EXT, {1'b1, 3'b000, 3'b011, 2'b01});
         rd(ADDR_A_HI, REG_EXT, {1'b1, 3'b000, 3'b010, 2'b00});
         rd(ADDR_MAIN, REG_OUTPUT_CURRENT_READING, {1'b1, cur_main >> 1});
         rd(ADDR_MAIN, REG_OUTPUT_POWER_READING, {1'b1, pow_main >> 1});
         rd(ADDR_A_HI, REG_OUTPUT_CURRENT_READING, {1'b1, cur_a});
         rd(ADDR_SYSTEM_POWER_INPUT, REG_OUTPUT_POWER_READING, {1'b1, system_power_input_code});
         rd(ADDR_SYSTEM_POWER_INPUT, REG_OUTPUT_CURRENT_READING, {1'b1, 8'((16'(aux_code) * 16'(code_tbl[7])) >> 8)});
         rd(ADDR_MAIN, 8'h33, 9'h100);
         rd(4'h5, REG_PEAK, 9'h000);
         @(posedge mclk);
         enable_pin <= 1'b0;
         repeat (6) @(negedge mclk);
         check("disable", 9'h01F, 9'({driver_enable_out, regulator_ready, pwm_mid}));
         @(posedge mclk);
         system_power_input <= 1'b1;
         reset_n <= 1'b0;
         repeat (2) @(negedge mclk);
      end
      repeat (5) @(posedge mclk);
      stop_test();
   end
endmodule : tb

// File: bench/vrsc_host.sv
// Host partner model for the serial voltage-ID read port.
// Assumes the device framing: idle edge, start bit, 4 address and 8 index bits,
// 16 turnaround clocks, then 8 data bits driven by the device.
module vrsc_host (
   output logic vid_clk,
   output logic vid_data_in,
   input wire logic vid_data_out,
   input wire logic vid_data_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   event frame_done;
   logic [8:0] got;
   logic [1:0] smp;

   // Link clock only runs inside frames; it rests low between them
   initial begin
      vid_clk = 1'b0;
      vid_data_in = 1'b0;
   end

   // One 6 ns link clock cycle; data set in the low phase, line sampled just before the rise
   task automatic edge_out(input logic bit_v);
      vid_data_in = bit_v;
      #3;
      smp = {~vid_data_oe_n, vid_data_out};
      vid_clk = 1'b1;
      #3;
      vid_clk = 1'b0;
   endtask : edge_out

   // Single-byte read; got holds {answered, data}
   task automatic read(input logic [3:0] addr, input logic [7:0] idx);
      logic [11:0] sh;
      sh = {addr, idx};
      edge_out(1'b0);
      edge_out(1'b1);
      for (int i = 11; i >= 0; i--) edge_out(sh[i]);
      // Turnaround: host line carries a changing pattern, not a held value
      for (int i = 0; i < 16; i++) edge_out(~vid_data_in);
      got = 9'h100;
      for (int i = 7; i >= 0; i--) begin
         edge_out(~vid_data_in);
         got[8] = got[8] & smp[1];
         got[i] = smp[1] & smp[0];
      end
      if (!got[8]) got = 9'h000;
      ->frame_done;
   endtask : read
endmodule : vrsc_host

// File: shared/vrsc_pkg.sv
// Constants, tables and helper functions for the strap loader and start-up block.
// Assumes a 100 MHz core clock and an 8-bit strap ADC scaled 2.5 V full scale.
package vrsc_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS = 10;
   localparam int SETTLE_US = 10;
   localparam int SETTLE_CYC = SETTLE_US * 1000 / CLK_NS;

   // ----------------------------------------
   // Strap pins, measured in this order
   // ----------------------------------------
   localparam logic [2:0] SP_ADDR = 3'h0;
   localparam logic [2:0] SP_BOOT = 3'h1;
   localparam logic [2:0] SP_FM = 3'h2;
   localparam logic [2:0] SP_FA = 3'h3;
   localparam logic [2:0] SP_MODE = 3'h4;
   localparam logic [2:0] SP_PKM = 3'h5;
   localparam logic [2:0] SP_PKA = 3'h6;
   localparam logic [2:0] SP_PKX = 3'h7;
   localparam int N_STRAP = 8;

   // Midpoints between adjacent resistor bins, in ADC codes
   localparam logic [7:0] BIN_MID [0:14] = '{8'h0C, 8'h11, 8'h16, 8'h1D, 8'h24, 8'h2C, 8'h36,
      8'h43, 8'h51, 8'h62, 8'h77, 8'h90, 8'hAE, 8'hD0, 8'hF0};

   // Boot table row: {main coarse, A coarse, main volt[1:0], A volt[1:0]}
   localparam logic [5:0] BOOT_TBL [0:15] = '{6'h00, 6'h01, 6'h04, 6'h05, 6'h30, 6'h32, 6'h38,
      6'h3A, 6'h10, 6'h12, 6'h14, 6'h16, 6'h20, 6'h28, 6'h21, 6'h29};
   localparam int BT_MC = 5;
   localparam int BT_AC = 4;
   localparam int BT_MV = 2;
   localparam int BT_AV = 0;
   localparam int MODE_DBL = 0;
   localparam int MODE_FLOOR = 1;

   // ----------------------------------------
   // Voltages and slew rates
   // ----------------------------------------
   localparam int V105_MV = 1050;
   localparam int V18_MV = 1800;
   localparam int STEP_FINE_MV = 5;
   localparam int STEP_COARSE_MV = 10;
   localparam int SR_TBL [0:2] = '{10, 30, 48};
   localparam logic [3:0] A_HI_BIN = 4'h6;

   // ----------------------------------------
   // Serial bus addresses, register indices, values
   // ----------------------------------------
   localparam logic [3:0] ADDR_MAIN = 4'h0;
   localparam logic [3:0] ADDR_A_LO = 4'h1;
   localparam logic [3:0] ADDR_A_HI = 4'h2;
   localparam logic [3:0] ADDR_SYSTEM_POWER_INPUT = 4'hD;
   localparam logic [7:0] REG_OUTPUT_CURRENT_READING = 8'h15;
   localparam logic [7:0] REG_OUTPUT_POWER_READING = 8'h18;
   localparam logic [7:0] REG_PEAK = 8'h21;
   localparam logic [7:0] REG_EXT = 8'h50;
   localparam logic [7:0] EXT_NORM = 8'h08;
   localparam logic [7:0] EXT_DBL = 8'h0D;
   localparam logic [5:0] LK_IDX_END = 6'h0C;
   localparam logic [5:0] LK_TURN_END = 6'h1C;
   localparam logic [5:0] LK_END = 6'h24;
   localparam logic [1:0] PS_ZERO = 2'h0;
   localparam logic [1:0] PS_ONE = 2'h1;

   typedef enum logic [4:0] {
      ST_LOCK = 5'h01, ST_COLLECT = 5'h02, ST_WAIT = 5'h04, ST_RAMP = 5'h08, ST_RUN = 5'h10
   } vrsc_state_e;

   // Nearest resistor bin of a strap code
   function automatic logic [3:0] vrsc_bin(input logic [7:0] code);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 15; i++) begin
         if (code > BIN_MID[i]) n = n + 4'h1;
      end
      return n;
   endfunction : vrsc_bin

   // Boot code in VID steps
   function automatic logic [8:0] vrsc_boot(input logic [1:0] vsel, input logic coarse);
      int mv;
      mv = (vsel == 2'h1) ? V105_MV : (vsel == 2'h2) ? V18_MV : 0;
      return 9'(mv / (coarse ? STEP_COARSE_MV : STEP_FINE_MV));
   endfunction : vrsc_boot

   // Clock cycles per VID step for the programmed slew
   function automatic logic [7:0] vrsc_step_cyc(input logic coarse, input logic [1:0] sr);
      int st;
      st = coarse ? STEP_COARSE_MV : STEP_FINE_MV;
      return 8'(st * 1000 / (SR_TBL[sr] * CLK_NS));
   endfunction : vrsc_step_cyc

endpackage : vrsc_pkg

// File: verilog/vrsc_top.sv
// Strap configuration loader, start-up sequencer and serial read port.
// Assumes straps are settled analog levels digitised by an external ADC,
// and that modulator, power-state and reading inputs share mclk.
module vrsc_top
   import vrsc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic enable_pin,
   input wire logic [3:0] phase_sense_input,
   input wire logic system_power_input,
   input wire logic [7:0] strap_code,
   input wire logic [1:0] first_pulse,
   input wire logic [1:0] power_state,
   input wire logic [1:0] light_load,
   input wire logic [7:0] cur_main,
   input wire logic [7:0] cur_a,
   input wire logic [7:0] pow_main,
   input wire logic [7:0] pow_a,
   input wire logic [7:0] system_power_input_code,
   input wire logic [7:0] aux_code,
   input wire logic vid_clk,
   input wire logic vid_data_in,
   output logic vid_data_out,
   output logic vid_data_oe_n,
   output logic [2:0] strap_sel,
   output logic strap_src_en,
   output logic driver_enable_out,
   output logic regulator_ready,
   output logic [4:0] pwm_mid,
   output logic [8:0] dac_main,
   output logic [8:0] dac_a,
   output logic [2:0] phase_count,
   output logic [3:0] freq_sel_main,
   output logic [3:0] freq_sel_a,
   output logic [1:0] rail_ripple,
   output logic [1:0] rail_dcm,
   output logic [1:0] freq_floor
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [14:0] pin_meta_q, pin_sync_q;
   wire [14:0] pin_raw = {enable_pin, system_power_input, phase_sense_input, strap_code, 1'b0};
   wire en_s = pin_sync_q[14];
   wire system_power_input_tied_s = pin_sync_q[13];
   wire [3:0] sense_s = pin_sync_q[12:9];
   wire [7:0] code_s = pin_sync_q[8:1];

   // Two flops before any logic reads a pin
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= pin_raw;
         pin_sync_q <= pin_meta_q;
      end
   end

   // ----------------------------------------
   // Collection and start-up sequencer
   // ----------------------------------------
   vrsc_state_e st_q, st_d;
   logic [15:0] settle_q;
   logic [2:0] sel_q;
   logic [7:0] raw_q [0:N_STRAP-1];
   logic [3:0] unused_q;
   logic system_power_input_off_q;
   logic [1:0] done_r;
   wire settled = (settle_q == 16'(SETTLE_CYC - 1));
   wire last_pin = (sel_q == 3'(N_STRAP - 1));

   // Next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_LOCK: st_d = ST_COLLECT;
         ST_COLLECT: if (settled && last_pin) st_d = ST_WAIT;
         ST_WAIT: if (en_s) st_d = ST_RAMP;
         ST_RAMP: if (!en_s) st_d = ST_WAIT; else if (&done_r) st_d = ST_RUN;
         ST_RUN: if (!en_s) st_d = ST_WAIT;
         default: st_d = ST_LOCK;
      endcase
   end

   // State, strap pointer and settle timer
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= ST_LOCK;
         settle_q <= '0;
         sel_q <= SP_ADDR;
      end else begin
         st_q <= st_d;
         settle_q <= (st_q != ST_COLLECT || settled) ? '0 : settle_q + 16'h0001;
         if (st_q == ST_COLLECT && settled && !last_pin) sel_q <= sel_q + 3'h1;
      end
   end

   // Latch raw strap codes while collecting; held until reset
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < N_STRAP; i++) raw_q[i] <= '0;
         unused_q <= '0;
         system_power_input_off_q <= 1'b0;
      end else if (st_q == ST_COLLECT) begin
         if (settled) raw_q[sel_q] <= code_s;
         unused_q <= sense_s;
         system_power_input_off_q <= system_power_input_tied_s;
      end
   end

   // ----------------------------------------
   // Strap decode
   // ----------------------------------------
   wire [3:0] bin_addr = vrsc_bin(raw_q[SP_ADDR]);
   wire [5:0] boot_row = BOOT_TBL[vrsc_bin(raw_q[SP_BOOT])];
   wire [3:0] bin_mode = vrsc_bin(raw_q[SP_MODE]);
   wire dbl = bin_mode[MODE_DBL];
   wire floor_en = bin_mode[MODE_FLOOR];
   wire [1:0] slew_sel = 2'(bin_addr % 4'h3);
   wire [3:0] addr_a = (bin_addr < A_HI_BIN) ? ADDR_A_LO : ADDR_A_HI;
   wire [1:0] coarse = {boot_row[BT_AC], boot_row[BT_MC]};
   wire [8:0] boot_m = vrsc_boot(boot_row[BT_MV+1:BT_MV], coarse[0]);
   wire [8:0] boot_a = vrsc_boot(boot_row[BT_AV+1:BT_AV], coarse[1]);
   wire [2:0] n_active = 3'(!unused_q[0]) + 3'(!unused_q[1]) + 3'(!unused_q[2]) + 3'(!unused_q[3]);
   wire collect_done = (st_q == ST_WAIT) || (st_q == ST_RAMP) || (st_q == ST_RUN);

   // Decoded settings to pins once collected
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         phase_count <= '0;
         freq_sel_main <= '0;
         freq_sel_a <= '0;
      end else if (collect_done) begin
         phase_count <= n_active;
         freq_sel_main <= vrsc_bin(raw_q[SP_FM]);
         freq_sel_a <= vrsc_bin(raw_q[SP_FA]);
      end
   end

   // Strap current source and pin select
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         strap_src_en <= 1'b0;
         strap_sel <= SP_ADDR;
      end else begin
         strap_src_en <= (st_d == ST_COLLECT);
         strap_sel <= sel_q;
      end
   end

   // ----------------------------------------
   // Reference ramp per rail
   // ----------------------------------------
   logic [8:0] dac_r [0:1];
   logic [1:0] live_r;
   wire [8:0] boot_r [0:1] = '{boot_m, boot_a};
   wire ramping = (st_q == ST_RAMP) || (st_q == ST_RUN);

   for (genvar r = 0; r < 2; r++) begin : g_rail
      logic [7:0] tick_q;
      wire [7:0] per = vrsc_step_cyc(coarse[r], slew_sel);
      wire at_top = (dac_r[r] == boot_r[r]);
      wire step = (tick_q >= per - 8'h01);
      assign done_r[r] = at_top;

      // Step the reference toward the boot code
      always_ff @(posedge mclk or negedge reset_n) begin
         if (!reset_n) begin
            tick_q <= '0;
            dac_r[r] <= '0;
            live_r[r] <= 1'b0;
         end else if (!ramping) begin
            tick_q <= '0;
            dac_r[r] <= '0;
            live_r[r] <= 1'b0;
         end else begin
            tick_q <= (step || at_top) ? '0 : tick_q + 8'h01;
            if (step && !at_top) dac_r[r] <= dac_r[r] + 9'h001;
            if (first_pulse[r]) live_r[r] <= 1'b1;
         end
      end
   end

   // Driver enable, ready, mid-level lanes
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         driver_enable_out <= 1'b0;
         regulator_ready <= 1'b0;
         pwm_mid <= '1;
         dac_main <= '0;
         dac_a <= '0;
      end else begin
         driver_enable_out <= ramping && en_s;
         regulator_ready <= (st_q == ST_RUN) && en_s;
         pwm_mid <= {!live_r[1], unused_q | {4{!live_r[0]}}};
         dac_main <= dac_r[0];
         dac_a <= dac_r[1];
      end
   end

   // ----------------------------------------
   // Conduction mode per rail
   // ----------------------------------------
   wire ps_hi = power_state[1];
   wire [1:0] single = {1'b1, (n_active == 3'h1) || (power_state != PS_ZERO)};
   wire [1:0] ripple_d = (power_state == PS_ONE) ? 2'b11 : single;
   wire [1:0] dcm_d = ps_hi ? light_load : 2'b00;

   // Mode outputs
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rail_ripple <= '0;
         rail_dcm <= '0;
         freq_floor <= '0;
      end else begin
         rail_ripple <= ripple_d;
         rail_dcm <= dcm_d;
         freq_floor <= dcm_d & {2{floor_en}};
      end
   end

   // ----------------------------------------
   // Register read data
   // ----------------------------------------
   logic [3:0] lk_addr_q;
   logic [7:0] lk_idx_q, hold_q;
   logic hit_q;
   wire [15:0] aux_prod = aux_code * raw_q[SP_PKX];
   wire [7:0] ext_m = dbl ? EXT_DBL : EXT_NORM;
   wire [7:0] output_current_reading_m = dbl ? {1'b0, cur_main[7:1]} : cur_main;
   wire [7:0] output_power_reading_m = dbl ? {1'b0, pow_main[7:1]} : pow_main;
   wire hit_m = (lk_addr_q == ADDR_MAIN);
   wire hit_a = (lk_addr_q == addr_a);
   wire hit_p = (lk_addr_q == ADDR_SYSTEM_POWER_INPUT) && !system_power_input_off_q;
   wire [7:0] v_output_current_reading = hit_m ? output_current_reading_m : hit_a ? cur_a : aux_prod[15:8];
   wire [7:0] v_output_power_reading = hit_m ? output_power_reading_m : hit_a ? pow_a : system_power_input_code;
   wire [7:0] v_peak = hit_m ? raw_q[SP_PKM] : hit_a ? raw_q[SP_PKA] : raw_q[SP_PKX];
   wire [7:0] v_ext = hit_m ? ext_m : EXT_NORM;
   wire [7:0] rd_data = (lk_idx_q == REG_OUTPUT_CURRENT_READING) ? v_output_current_reading : (lk_idx_q == REG_OUTPUT_POWER_READING) ? v_output_power_reading :
      (lk_idx_q == REG_PEAK) ? v_peak : (lk_idx_q == REG_EXT) ? v_ext : 8'h00;
   wire rd_hit = (hit_m || hit_a || hit_p) && collect_done;

   // ----------------------------------------
   // Request / acknowledge crossing
   // ----------------------------------------
   logic req_tgl_q, ack_tgl_q;
   logic req_m1_q, req_m2_q, req_m3_q;
   logic ack_l1_q, ack_l2_q;
   wire req_new = req_m2_q ^ req_m3_q;

   // Capture read word on each request toggle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         req_m1_q <= 1'b0;
         req_m2_q <= 1'b0;
         req_m3_q <= 1'b0;
         ack_tgl_q <= 1'b0;
         hold_q <= '0;
         hit_q <= 1'b0;
      end else begin
         req_m1_q <= req_tgl_q;
         req_m2_q <= req_m1_q;
         req_m3_q <= req_m2_q;
         if (req_new) begin
            hold_q <= rd_data;
            hit_q <= rd_hit;
            ack_tgl_q <= !ack_tgl_q;
         end
      end
   end

   // ----------------------------------------
   // Serial link, vid_clk domain
   // ----------------------------------------
   logic [5:0] cnt_q;
   logic [11:0] sh_q;
   logic [7:0] tx_q;
   logic drv_q;
   wire idle = (cnt_q == 6'h00);
   wire answer = (ack_l2_q == req_tgl_q) && hit_q;

   // Shift in address and index, answer after turnaround
   always_ff @(posedge vid_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
         sh_q <= '0;
         tx_q <= '0;
         drv_q <= 1'b0;
         req_tgl_q <= 1'b0;
         lk_addr_q <= '0;
         lk_idx_q <= '0;
         ack_l1_q <= 1'b0;
         ack_l2_q <= 1'b0;
      end else begin
         ack_l1_q <= ack_tgl_q;
         ack_l2_q <= ack_l1_q;
         if (idle) begin
            if (vid_data_in) cnt_q <= 6'h01;
         end else if (cnt_q == LK_END) begin
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_q + 6'h01;
         end
         if (!idle && cnt_q <= LK_IDX_END) sh_q <= {sh_q[10:0], vid_data_in};
         if (cnt_q == LK_IDX_END) begin
            lk_addr_q <= sh_q[10:7];
            lk_idx_q <= {sh_q[6:0], vid_data_in};
            req_tgl_q <= !req_tgl_q;
         end
         if (cnt_q == LK_TURN_END) begin
            drv_q <= answer;
            tx_q <= hold_q;
         end else if (cnt_q == LK_END || idle) begin
            drv_q <= 1'b0;
         end else if (drv_q) begin
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   assign vid_data_out = tx_q[7];
   assign vid_data_oe_n = !drv_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   sequence s_enable;
      (st_q == ST_WAIT) && en_s ##1 (st_q == ST_RAMP);
   endsequence

   sequence s_disable;
      ramping && !en_s ##1 (st_q == ST_WAIT);
   endsequence

   property p_collect_mid;
      (st_q == ST_COLLECT) |=> (pwm_mid == 5'h1F) && !driver_enable_out;
   endproperty
   a_collect_mid: assert property (p_collect_mid) else $error("lanes not mid during collect");

   property p_driver_enable_out;
      s_enable |=> driver_enable_out;
   endproperty
   a_driver_enable_out: assert property (p_driver_enable_out) else $error("driver enable not raised");

   property p_ramp_up;
      (st_q == ST_RAMP) && $past(st_q == ST_RAMP) |-> dac_r[0] >= $past(dac_r[0]) && dac_r[0] <= boot_m;
   endproperty
   a_ramp_up: assert property (p_ramp_up) else $error("main reference not ramping up");

   property p_live;
      ramping && en_s && first_pulse[0] ##1 ramping && en_s |=> !pwm_mid[0] || unused_q[0];
   endproperty
   a_live: assert property (p_live) else $error("lane stuck mid after pulse");

   property p_disable;
      s_disable |=> ##1 (pwm_mid == 5'h1F) && !driver_enable_out && !regulator_ready;
   endproperty
   a_disable: assert property (p_disable) else $error("disable left lanes active");

   property p_ready;
      regulator_ready |-> (dac_main == boot_m) && (dac_a == boot_a) && collect_done;
   endproperty
   a_ready: assert property (p_ready) else $error("ready before ramp done");

   property p_system_power_input_off;
      req_new && (lk_addr_q == ADDR_SYSTEM_POWER_INPUT) && system_power_input_off_q && (addr_a != ADDR_SYSTEM_POWER_INPUT) |=> !hit_q;
   endproperty
   a_system_power_input_off: assert property (p_system_power_input_off) else $error("silenced address answered");

   property p_ext;
      req_new && hit_m && (lk_idx_q == REG_EXT) |=> hold_q == (dbl ? EXT_DBL : EXT_NORM);
   endproperty
   a_ext: assert property (p_ext) else $error("range extension value wrong");

   property p_ps1;
      (power_state == PS_ONE) |=> (rail_ripple == 2'b11) && (rail_dcm == 2'b00);
   endproperty
   a_ps1: assert property (p_ps1) else $error("state one not ripple continuous");

   property p_floor;
      !power_state[1] |=> (freq_floor == 2'b00) && (rail_dcm == 2'b00);
   endproperty
   a_floor: assert property (p_floor) else $error("floor or dcm outside light states");

   property p_hold;
      collect_done && $past(collect_done) |-> $stable(raw_q[SP_ADDR]) && $stable(unused_q);
   endproperty
   a_hold: assert property (p_hold) else $error("latched straps changed");

endmodule : vrsc_top
